/* hw/timer16_pkg.sv */
package timer16_pkg;
	// register offsets on the byte bus
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h01;
	localparam logic [7:0] ADDR_CNT_LO = 8'h02;
	localparam logic [7:0] ADDR_CNT_HI = 8'h03;
	localparam logic [7:0] ADDR_CMPA_LO = 8'h04;
	localparam logic [7:0] ADDR_CMPA_HI = 8'h05;
	localparam logic [7:0] ADDR_CMPB_LO = 8'h06;
	localparam logic [7:0] ADDR_CMPB_HI = 8'h07;
	localparam logic [7:0] ADDR_CAP_LO = 8'h08;
	localparam logic [7:0] ADDR_CAP_HI = 8'h09;
	localparam logic [7:0] ADDR_FLAG = 8'h0A;
	localparam logic [7:0] ADDR_MASK = 8'h0B;
	localparam logic [7:0] ADDR_ACMP = 8'h0C;
	// field positions
	localparam int WGML_MSB = 1;
	localparam int WGML_LSB = 0;
	localparam int WGMH_MSB = 4;
	localparam int WGMH_LSB = 3;
	localparam int CS_MSB = 2;
	localparam int CS_LSB = 0;
	localparam int NFE_BIT = 7;
	localparam int EDGE_BIT = 6;
	localparam int ACMP_SEL_BIT = 0;
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP = 3;
	// clock select codes and prescaler tap masks
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [9:0] PS_M8 = 10'h007;
	localparam logic [9:0] PS_M64 = 10'h03F;
	localparam logic [9:0] PS_M256 = 10'h0FF;
	localparam logic [9:0] PS_M1024 = 10'h3FF;
	// fixed top values, bottom and unit steps
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [9:0] PS_ONE = 10'h001;
	typedef enum logic [3:0] {
		WGM_NORMAL, WGM_PC8, WGM_PC9, WGM_PC10,
		WGM_CTC_A, WGM_FAST8, WGM_FAST9, WGM_FAST10,
		WGM_PFC_CAP, WGM_PFC_A, WGM_PC_CAP, WGM_PC_A,
		WGM_CTC_CAP, WGM_RSVD, WGM_FAST_CAP, WGM_FAST_A
	} wgm_t;
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic acmp_sel;
		logic [7:0] temp;
		logic [15:0] count;
		logic dir_up;
		logic block;
		logic [15:0] cmpa;
		logic [15:0] cmpa_buf;
		logic [15:0] cmpb;
		logic [15:0] cmpb_buf;
		logic [15:0] cap;
		logic [3:0] flags;
		logic [3:0] mask;
		logic [9:0] presc;
		logic pin_s1;
		logic pin_s2;
		logic acmp_s1;
		logic acmp_s2;
		logic ext_s1;
		logic ext_s2;
		logic ext_prev;
		logic [3:0] filt;
		logic filt_out;
		logic edge_prev;
		logic [7:0] rdata;
		logic at_top;
		logic at_bottom;
	} state_t;
endpackage : timer16_pkg

/* hw/timer16_counter_capture.sv */
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
// Contract
// - tick clears, increments or decrements count
// - no clock source holds count, cpu access
// - cpu count write beats count/clear
// - high byte via shared temp byte
// - clock select picks source and edge
// - four-bit mode across two control registers
// - overflow flag set per mode, irq
// - top from constant, compare a, capture
// - compare a top is double buffered in pwm modes only
// - bottom indication when count is zero
// - compare matches set compare flags
// - qualifying edge copies count to capture outside capture-top modes
// - capture flag set with capture copy
// - capture irq enable, ack/write-one clears
// - capture low read latches high byte
// - capture writes only in capture-top modes
// - control registers accessed directly
// - one flag register, one mask register
// - filter needs four agreeing samples
// - filter adds five system clocks
// - comparator select switches capture source
module timer16_counter_capture
	import timer16_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register bus
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// pins, asynchronous
	input wire logic i_ext_count_pin,
	input wire logic i_capture_pin,
	input wire logic i_comparator_out,
	// interrupt requests and service acks
	input wire logic [3:0] i_irq_ack,
	output logic o_irq_overflow,
	output logic o_irq_cmp_a,
	output logic o_irq_cmp_b,
	output logic o_irq_capture,
	// limit indications
	output logic o_at_top,
	output logic o_at_bottom
);
	state_t st_ff;
	state_t nxt_st;
	wgm_t wgm;
	logic [2:0] cs;
	logic [15:0] top_val;
	logic updown;
	logic pwm;
	logic cap_top;
	logic upd_bot;
	logic tick;
	logic cnt_wr;
	logic cap_wr;
	logic cap_src;
	logic cap_lvl;
	logic cap_evt;
	logic buf_upd;
	logic [3:0] set_f;
	logic [3:0] clr_f;
	logic [15:0] wval;

	// all timer behaviour in one next-state process
	always_comb begin
		nxt_st = st_ff;
		wgm = wgm_t'({st_ff.ctrl_b[WGMH_MSB:WGMH_LSB], st_ff.ctrl_a[WGML_MSB:WGML_LSB]});
		cs = st_ff.ctrl_b[CS_MSB:CS_LSB];
		wval = {st_ff.temp, i_wdata};
		top_val = TOP_MAX;
		updown = 1'b0;
		pwm = 1'b0;
		cap_top = 1'b0;
		upd_bot = 1'b0;
		// mode decode: top source, direction, buffering
		unique case (wgm)
			WGM_NORMAL: top_val = TOP_MAX;
			WGM_PC8: begin
				top_val = TOP_8;
				updown = 1'b1;
				pwm = 1'b1;
			end
			WGM_PC9: begin
				top_val = TOP_9;
				updown = 1'b1;
				pwm = 1'b1;
			end
			WGM_PC10: begin
				top_val = TOP_10;
				updown = 1'b1;
				pwm = 1'b1;
			end
			WGM_CTC_A: top_val = st_ff.cmpa;
			WGM_FAST8: begin
				top_val = TOP_8;
				pwm = 1'b1;
			end
			WGM_FAST9: begin
				top_val = TOP_9;
				pwm = 1'b1;
			end
			WGM_FAST10: begin
				top_val = TOP_10;
				pwm = 1'b1;
			end
			WGM_PFC_CAP: begin
				top_val = st_ff.cap;
				cap_top = 1'b1;
				updown = 1'b1;
				pwm = 1'b1;
				upd_bot = 1'b1;
			end
			WGM_PFC_A: begin
				top_val = st_ff.cmpa;
				updown = 1'b1;
				pwm = 1'b1;
				upd_bot = 1'b1;
			end
			WGM_PC_CAP: begin
				top_val = st_ff.cap;
				cap_top = 1'b1;
				updown = 1'b1;
				pwm = 1'b1;
			end
			WGM_PC_A: begin
				top_val = st_ff.cmpa;
				updown = 1'b1;
				pwm = 1'b1;
			end
			WGM_CTC_CAP: begin
				top_val = st_ff.cap;
				cap_top = 1'b1;
			end
			WGM_RSVD: top_val = TOP_MAX;
			WGM_FAST_CAP: begin
				top_val = st_ff.cap;
				cap_top = 1'b1;
				pwm = 1'b1;
			end
			WGM_FAST_A: begin
				top_val = st_ff.cmpa;
				pwm = 1'b1;
			end
		endcase

		// input synchronisers, first stage feeds only the second
		nxt_st.pin_s1 = i_capture_pin;
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.acmp_s1 = i_comparator_out;
		nxt_st.acmp_s2 = st_ff.acmp_s1;
		nxt_st.ext_s1 = i_ext_count_pin;
		nxt_st.ext_s2 = st_ff.ext_s1;
		nxt_st.ext_prev = st_ff.ext_s2;
		nxt_st.presc = st_ff.presc + PS_ONE;

		// clock select; prescaler free-runs so taps stay phase-locked
		unique case (cs)
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (st_ff.presc & PS_M8) == '0;
			CS_DIV64: tick = (st_ff.presc & PS_M64) == '0;
			CS_DIV256: tick = (st_ff.presc & PS_M256) == '0;
			CS_DIV1024: tick = (st_ff.presc & PS_M1024) == '0;
			CS_EXT_FALL: tick = st_ff.ext_prev & ~st_ff.ext_s2;
			CS_EXT_RISE: tick = ~st_ff.ext_prev & st_ff.ext_s2;
		endcase

		cnt_wr = i_wr && (i_addr == ADDR_CNT_LO);
		cap_wr = i_wr && (i_addr == ADDR_CAP_LO) && cap_top;
		set_f = '0;

		// counter; a cpu write overrides any tick action
		if (cnt_wr) begin
			nxt_st.count = wval;
			nxt_st.block = 1'b1;
		end else if (tick) begin
			nxt_st.block = 1'b0;
			if (updown) begin
				if (st_ff.dir_up && st_ff.count == top_val) begin
					nxt_st.dir_up = 1'b0;
					nxt_st.count = st_ff.count - CNT_ONE;
				end else if (!st_ff.dir_up && st_ff.count == BOTTOM) begin
					nxt_st.dir_up = 1'b1;
					nxt_st.count = st_ff.count + CNT_ONE;
				end else if (st_ff.dir_up) begin
					nxt_st.count = st_ff.count + CNT_ONE;
				end else begin
					nxt_st.count = st_ff.count - CNT_ONE;
				end
			end else begin
				nxt_st.dir_up = 1'b1;
				nxt_st.count = (st_ff.count == top_val) ? BOTTOM : st_ff.count + CNT_ONE;
			end
		end

		// overflow point depends on mode
		if (tick && !cnt_wr) begin
			if (updown) begin
				set_f[FLG_OVF] = (st_ff.count == BOTTOM);
			end else if (pwm) begin
				set_f[FLG_OVF] = (st_ff.count == top_val);
			end else begin
				set_f[FLG_OVF] = (st_ff.count == TOP_MAX);
			end
		end

		// compare match; a count write masks the next tick's match
		if (tick && !st_ff.block && !cnt_wr) begin
			set_f[FLG_CMPA] = (st_ff.count == st_ff.cmpa);
			set_f[FLG_CMPB] = (st_ff.count == st_ff.cmpb);
		end

		// compare buffer update at top, or bottom in freq-correct modes
		buf_upd = pwm && tick && !cnt_wr &&
			(upd_bot ? (st_ff.count == BOTTOM) : (st_ff.count == top_val));
		if (buf_upd) begin
			nxt_st.cmpa = st_ff.cmpa_buf;
			nxt_st.cmpb = st_ff.cmpb_buf;
		end
		if (i_wr && i_addr == ADDR_CMPA_LO) begin
			nxt_st.cmpa_buf = wval;
			if (!pwm) begin
				nxt_st.cmpa = wval;
			end
		end
		if (i_wr && i_addr == ADDR_CMPB_LO) begin
			nxt_st.cmpb_buf = wval;
			if (!pwm) begin
				nxt_st.cmpb = wval;
			end
		end

		// capture source, noise filter and edge detector
		cap_src = st_ff.acmp_sel ? st_ff.acmp_s2 : st_ff.pin_s2;
		nxt_st.filt = {st_ff.filt[2:0], cap_src};
		if (st_ff.filt == '1) begin
			nxt_st.filt_out = 1'b1;
		end else if (st_ff.filt == '0) begin
			nxt_st.filt_out = 1'b0;
		end
		cap_lvl = st_ff.ctrl_b[NFE_BIT] ? st_ff.filt_out : cap_src;
		nxt_st.edge_prev = cap_lvl;
		cap_evt = !cap_top && (st_ff.ctrl_b[EDGE_BIT] ? (cap_lvl && !st_ff.edge_prev) :
			(!cap_lvl && st_ff.edge_prev));
		if (cap_evt) begin
			nxt_st.cap = st_ff.count;
			set_f[FLG_CAP] = 1'b1;
		end else if (cap_wr) begin
			nxt_st.cap = wval;
		end

		// flags: ack or write-one clears, a same-cycle set wins
		clr_f = i_irq_ack;
		if (i_wr && i_addr == ADDR_FLAG) begin
			clr_f = clr_f | i_wdata[3:0];
		end
		nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;

		// plain byte registers and high-byte writes to temp
		if (i_wr) begin
			unique case (i_addr)
				ADDR_CTRL_A: nxt_st.ctrl_a = i_wdata;
				ADDR_CTRL_B: nxt_st.ctrl_b = i_wdata;
				ADDR_CNT_HI, ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAP_HI: nxt_st.temp = i_wdata;
				ADDR_MASK: nxt_st.mask = i_wdata[3:0];
				ADDR_ACMP: nxt_st.acmp_sel = i_wdata[ACMP_SEL_BIT];
				default: ;
			endcase
		end

		// read data stands one cycle, zero otherwise and off-map
		nxt_st.rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				ADDR_CTRL_A: nxt_st.rdata = st_ff.ctrl_a;
				ADDR_CTRL_B: nxt_st.rdata = st_ff.ctrl_b;
				ADDR_CNT_LO: begin
					nxt_st.rdata = st_ff.count[7:0];
					nxt_st.temp = st_ff.count[15:8];
				end
				ADDR_CNT_HI: nxt_st.rdata = st_ff.temp;
				ADDR_CMPA_LO: nxt_st.rdata = st_ff.cmpa_buf[7:0];
				ADDR_CMPA_HI: nxt_st.rdata = st_ff.cmpa_buf[15:8];
				ADDR_CMPB_LO: nxt_st.rdata = st_ff.cmpb_buf[7:0];
				ADDR_CMPB_HI: nxt_st.rdata = st_ff.cmpb_buf[15:8];
				ADDR_CAP_LO: begin
					nxt_st.rdata = st_ff.cap[7:0];
					nxt_st.temp = st_ff.cap[15:8];
				end
				ADDR_CAP_HI: nxt_st.rdata = st_ff.temp;
				ADDR_FLAG: nxt_st.rdata = {4'h0, st_ff.flags};
				ADDR_MASK: nxt_st.rdata = {4'h0, st_ff.mask};
				ADDR_ACMP: nxt_st.rdata = {7'h00, st_ff.acmp_sel};
				default: nxt_st.rdata = '0;
			endcase
		end

		// registered limit indications follow the next count
		nxt_st.at_bottom = (nxt_st.count == BOTTOM);
		nxt_st.at_top = (nxt_st.count == top_val);
	end

	// single state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= '0;
			st_ff.at_bottom <= 1'b1; // count resets to zero, so bottom holds from the start
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs; masking kept outside the flags so software sees raw state
	assign o_rdata = st_ff.rdata;
	assign o_irq_overflow = st_ff.flags[FLG_OVF] & st_ff.mask[FLG_OVF];
	assign o_irq_cmp_a = st_ff.flags[FLG_CMPA] & st_ff.mask[FLG_CMPA];
	assign o_irq_cmp_b = st_ff.flags[FLG_CMPB] & st_ff.mask[FLG_CMPB];
	assign o_irq_capture = st_ff.flags[FLG_CAP] & st_ff.mask[FLG_CAP];
	assign o_at_top = st_ff.at_top;
	assign o_at_bottom = st_ff.at_bottom;

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	cnt_write_prio_a: assert property (cnt_wr |=> st_ff.count == {$past(st_ff.temp), $past(i_wdata)})
		else $error("count write lost");
	stopped_hold_a: assert property (cs == CS_STOP && !cnt_wr |=> $stable(st_ff.count))
		else $error("stopped counter moved");
	count_step_a: assert property (tick && !cnt_wr && !updown && st_ff.count != top_val
		|=> st_ff.count == $past(st_ff.count) + CNT_ONE)
		else $error("count did not step");
	temp_load_a: assert property (i_rd && i_addr == ADDR_CNT_LO
		|=> st_ff.temp == $past(st_ff.count[15:8]) ##1 1'b1)
		else $error("temp not loaded");
	cap_copy_a: assert property (cap_evt |=> st_ff.cap == $past(st_ff.count) && st_ff.flags[FLG_CAP])
		else $error("capture copy or flag missing");
	cap_read_pair_a: assert property (i_rd && i_addr == ADDR_CAP_LO && !i_wr
		##1 i_rd && i_addr == ADDR_CAP_HI |=> o_rdata == $past(st_ff.cap[15:8], 2))
		else $error("capture high byte wrong");
	cap_wr_guard_a: assert property (i_wr && i_addr == ADDR_CAP_LO && !cap_top && !cap_evt
		|=> $stable(st_ff.cap))
		else $error("capture written outside capture-top mode");
	bottom_ind_a: assert property (o_at_bottom == (st_ff.count == BOTTOM))
		else $error("bottom indication wrong");
	irq_gate_a: assert property (set_f[FLG_CAP] && st_ff.mask[FLG_CAP] && !(i_wr && i_addr == ADDR_MASK)
		|=> o_irq_capture)
		else $error("capture irq not raised");
	pwm_buffer_a: assert property (pwm && i_wr && i_addr == ADDR_CMPA_LO && !buf_upd
		|=> $stable(st_ff.cmpa))
		else $error("compare a bypassed its buffer");
	flag_set_wins_a: assert property (set_f[FLG_CMPA] && i_irq_ack[FLG_CMPA] |=> st_ff.flags[FLG_CMPA])
		else $error("compare flag set lost to clear");
	filt_settle_a: assert property (st_ff.filt == '1 |=> st_ff.filt_out)
		else $error("filter output not settled");
	ctrl_direct_a: assert property (i_wr && i_addr == ADDR_CTRL_B |=> st_ff.ctrl_b == $past(i_wdata))
		else $error("control write lost");

	cap_seen_c: cover property (cap_evt ##1 st_ff.flags[FLG_CAP]);
	ovf_seen_c: cover property (set_f[FLG_OVF] && updown);
	match_seen_c: cover property (set_f[FLG_CMPA] && set_f[FLG_CMPB]);
	buf_upd_c: cover property (buf_upd && st_ff.cmpa != st_ff.cmpa_buf);
	updown_turn_c: cover property (tick && updown && st_ff.dir_up && st_ff.count == top_val);
endmodule : timer16_counter_capture

/* verification/cpu_bus_model.sv */
`timescale 1ns/10ps
// cpu side of the byte register bus; the timer never stalls, so no wait loop
module cpu_bus_model (
	// clock
	input wire logic i_clk,
	// bus toward the timer
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [7:0] i_rdata
);
	// idle bus from time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// one write cycle, strobe dropped at the taking edge
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask : wr8
	// read data only stands in the cycle after the strobe
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : rd8
	// high byte parks in the shared temp, low byte commits the word
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr8(a + 8'h01, d[15:8]);
		wr8(a, d[7:0]);
	endtask : wr16
	// low first so the high byte is frozen with it; the two strobes run back to back
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_addr <= a + 8'h01;
		#1;
		d[7:0] = i_rdata;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d[15:8] = i_rdata;
	endtask : rd16
endmodule : cpu_bus_model

/* verification/timer16_counter_capture_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("[ERR] %s expected %h seen %h", nm, exp, got); \
	end \
end
module timer16_counter_capture_tb_top;
	import timer16_pkg::*;
	logic i_clk;
	logic i_rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic ext_pin;
	logic cap_pin;
	logic comp_out;
	logic [3:0] irq_ack;
	logic irq_ov;
	logic irq_ca;
	logic irq_cb;
	logic irq_cap;
	logic at_top;
	logic at_bot;
	int n_mismatch = 0;
	int check_count = 0;
	int m_cnt;
	int m_up;
	int lo_t;
	int divs[6] = '{1, 1, 8, 64, 256, 1024};
	logic [7:0] d8;
	logic [15:0] d16;
	logic [15:0] v;
	logic [7:0] regs[7] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_FLAG, ADDR_MASK, ADDR_ACMP, 8'h0D, 8'h7F};
	// design under test
	timer16_counter_capture dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_ext_count_pin(ext_pin), .i_capture_pin(cap_pin),
		.i_comparator_out(comp_out), .i_irq_ack(irq_ack), .o_irq_overflow(irq_ov), .o_irq_cmp_a(irq_ca),
		.o_irq_cmp_b(irq_cb), .o_irq_capture(irq_cap), .o_at_top(at_top), .o_at_bottom(at_bot));
	// software side
	cpu_bus_model u_cpu (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
	// control b image: filter, edge, mode high, clock select
	function automatic logic [7:0] cb(input logic ed, input logic nf, input logic [1:0] wh, input logic [2:0] cs);
		return {nf, ed, 1'b0, wh, cs};
	endfunction : cb
	// start the clock, then stop it k idle cycles later: k+2 ticks at full rate
	task automatic run(input logic [7:0] b, input int k);
		u_cpu.wr8(ADDR_CTRL_B, b);
		repeat (k) @(posedge i_clk);
		u_cpu.wr8(ADDR_CTRL_B, b & 8'hF8);
	endtask : run
	// one service pulse on the ack lines
	task automatic ack(input logic [3:0] m);
		@(posedge i_clk);
		irq_ack <= m;
		@(posedge i_clk);
		irq_ack <= 4'h0;
		#1;
	endtask : ack
	task automatic close_out();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// hang guard, well beyond the longest sequence
	initial begin
		repeat (40000) @(posedge i_clk);
		n_mismatch++;
		close_out();
	end
	initial begin
		i_rst_n = 1'b0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		comp_out = 1'b0;
		irq_ack = 4'h0;
		void'($urandom(51767));
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		`CHK("at_bottom", 1'b1, at_bot)
		`CHK("at_top", 1'b0, at_top)
		// reset values, unmapped places read zero and ignore writes
		u_cpu.wr8(8'h0D, 8'hFF);
		foreach (regs[i]) begin
			u_cpu.rd8(regs[i], d8);
			`CHK("reset_reg", 8'h00, d8)
		end
		// control registers straight through, no temp
		d8 = 8'($urandom);
		u_cpu.wr8(ADDR_CTRL_A, d8);
		u_cpu.rd8(ADDR_CTRL_A, v[7:0]);
		`CHK("ctrl_a", d8, v[7:0])
		u_cpu.wr8(ADDR_CTRL_A, 8'h00);
		d8 = 8'($urandom) & 8'hF8;
		u_cpu.wr8(ADDR_CTRL_B, d8);
		u_cpu.rd8(ADDR_CTRL_B, v[7:0]);
		`CHK("ctrl_b", d8, v[7:0])
		u_cpu.wr8(ADDR_CTRL_B, 8'h00);
		// stopped counter keeps random words
		repeat (3) begin
			v = 16'($urandom);
			u_cpu.wr16(ADDR_CNT_LO, v);
			repeat (20) @(posedge i_clk);
			u_cpu.rd16(ADDR_CNT_LO, d16);
			`CHK("count_hold", v, d16)
		end
		u_cpu.wr16(ADDR_CMPB_LO, 16'h8000);
		u_cpu.rd16(ADDR_CMPB_LO, d16);
		`CHK("cmp_b", 16'h8000, d16)
		// every internal rate; prescaler phase unknown, so one tick of slack
		for (int cs = 1; cs < 6; cs++) begin
			u_cpu.wr16(ADDR_CNT_LO, 16'h0000);
			run(cb(0, 0, 2'b00, 3'(cs)), 2046);
			u_cpu.rd16(ADDR_CNT_LO, d16);
			lo_t = 2048 / divs[cs];
			`CHK("ps_ticks", 1'b1, (cs == 1) ? d16 == 16'(lo_t) : (d16 >= lo_t && d16 <= lo_t + 1))
		end
		// count write while running wins, then counting resumes
		u_cpu.wr8(ADDR_CTRL_B, cb(0, 0, 2'b00, CS_DIV1));
		u_cpu.wr16(ADDR_CNT_LO, 16'h4000);
		u_cpu.wr8(ADDR_CTRL_B, 8'h00);
		u_cpu.rd16(ADDR_CNT_LO, d16);
		`CHK("cnt_write_win", 16'h4002, d16)
		// external pin, both edge codes, three pulses
		for (int cs = 6; cs < 8; cs++) begin
			u_cpu.wr16(ADDR_CNT_LO, 16'h0000);
			u_cpu.wr8(ADDR_CTRL_B, cb(0, 0, 2'b00, 3'(cs)));
			repeat (3) begin
				@(posedge i_clk);
				ext_pin <= 1'b1;
				repeat (4) @(posedge i_clk);
				ext_pin <= 1'b0;
				repeat (4) @(posedge i_clk);
			end
			u_cpu.wr8(ADDR_CTRL_B, 8'h00);
			u_cpu.rd16(ADDR_CNT_LO, d16);
			`CHK("ext_ticks", 16'h0003, d16)
		end
		// clear on compare a top
		u_cpu.wr8(ADDR_CTRL_B, cb(0, 0, 2'b01, CS_STOP));
		u_cpu.wr16(ADDR_CMPA_LO, 16'h0010);
		u_cpu.wr16(ADDR_CMPB_LO, 16'h000F);
		u_cpu.wr16(ADDR_CNT_LO, 16'h000E);
		u_cpu.wr8(ADDR_FLAG, 8'h0F);
		m_cnt = 14;
		repeat (4) m_cnt = (m_cnt == 16) ? 0 : m_cnt + 1;
		run(cb(0, 0, 2'b01, CS_DIV1), 2);
		u_cpu.rd16(ADDR_CNT_LO, d16);
		`CHK("ctc_count", 16'(m_cnt), d16)
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("ctc_flags", 8'h06, d8)
		u_cpu.wr8(ADDR_MASK, 8'h06);
		#1;
		`CHK("irq_cmp_a", 1'b1, irq_ca)
		`CHK("irq_cmp_b", 1'b1, irq_cb)
		u_cpu.wr8(ADDR_FLAG, 8'h06);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("flag_w1c", 8'h00, d8)
		`CHK("irq_cmp_clear", 1'b0, irq_ca | irq_cb)
		// overflow in normal mode, masked request, service ack
		u_cpu.wr8(ADDR_CTRL_B, 8'h00);
		u_cpu.wr16(ADDR_CNT_LO, 16'hFFFE);
		run(cb(0, 0, 2'b00, CS_DIV1), 2);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("ovf_flag", 8'h01, d8)
		`CHK("ovf_masked", 1'b0, irq_ov)
		u_cpu.wr8(ADDR_MASK, 8'h01);
		#1;
		`CHK("ovf_irq", 1'b1, irq_ov)
		ack(4'h1);
		`CHK("ovf_acked", 1'b0, irq_ov)
		// phase correct 8-bit: turns at top, compare a write waits in its buffer
		u_cpu.wr8(ADDR_CTRL_A, 8'h01);
		u_cpu.wr16(ADDR_CMPA_LO, 16'h0020);
		u_cpu.wr16(ADDR_CNT_LO, 16'h00FE);
		m_cnt = 254;
		m_up = 1;
		repeat (4) begin
			if (m_cnt == 255) begin
				m_up = 0;
			end
			m_cnt = (m_up == 1) ? m_cnt + 1 : m_cnt - 1;
		end
		run(cb(0, 0, 2'b00, CS_DIV1), 2);
		u_cpu.rd16(ADDR_CNT_LO, d16);
		`CHK("pc_count", 16'(m_cnt), d16)
		u_cpu.rd16(ADDR_CMPA_LO, d16);
		`CHK("cmpa_buf", 16'h0020, d16)
		u_cpu.wr8(ADDR_CTRL_A, 8'h00);
		// rising capture, then falling ignored
		u_cpu.wr8(ADDR_CTRL_B, cb(1, 0, 2'b00, CS_STOP));
		u_cpu.wr16(ADDR_CNT_LO, 16'hABCD);
		u_cpu.wr8(ADDR_FLAG, 8'h0F);
		u_cpu.wr8(ADDR_MASK, 8'h08);
		cap_pin <= 1'b1;
		repeat (12) @(posedge i_clk);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("cap_flag", 8'h08, d8)
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("cap_val", 16'hABCD, d16)
		`CHK("cap_irq", 1'b1, irq_cap)
		ack(4'h8);
		`CHK("cap_acked", 1'b0, irq_cap)
		u_cpu.wr16(ADDR_CNT_LO, 16'h1234);
		cap_pin <= 1'b0;
		repeat (12) @(posedge i_clk);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("fall_ignored", 8'h00, d8)
		// falling edge setting
		u_cpu.wr8(ADDR_CTRL_B, cb(0, 0, 2'b00, CS_STOP));
		cap_pin <= 1'b1;
		repeat (12) @(posedge i_clk);
		cap_pin <= 1'b0;
		repeat (12) @(posedge i_clk);
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("cap_fall", 16'h1234, d16)
		// filter drops a short pulse, passes a steady level
		u_cpu.wr8(ADDR_CTRL_B, cb(1, 1, 2'b00, CS_STOP));
		u_cpu.wr16(ADDR_CNT_LO, 16'h0F0F);
		u_cpu.wr8(ADDR_FLAG, 8'h0F);
		cap_pin <= 1'b1;
		repeat (2) @(posedge i_clk);
		cap_pin <= 1'b0;
		repeat (12) @(posedge i_clk);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("filt_drop", 8'h00, d8)
		cap_pin <= 1'b1;
		repeat (14) @(posedge i_clk);
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("filt_pass", 16'h0F0F, d16)
		// comparator as source; switching may capture, so flags cleared after
		u_cpu.wr8(ADDR_CTRL_B, cb(1, 0, 2'b00, CS_STOP));
		u_cpu.wr8(ADDR_ACMP, 8'h01);
		u_cpu.wr8(ADDR_FLAG, 8'h0F);
		u_cpu.wr16(ADDR_CNT_LO, 16'h1111);
		comp_out <= 1'b1;
		repeat (12) @(posedge i_clk);
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("cap_comp", 16'h1111, d16)
		u_cpu.wr8(ADDR_ACMP, 8'h00);
		// capture write refused outside capture-top modes
		u_cpu.wr16(ADDR_CAP_LO, 16'h5A5A);
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("cap_wr_refused", 16'h1111, d16)
		u_cpu.wr8(ADDR_CTRL_B, cb(1, 0, 2'b11, CS_STOP));
		u_cpu.wr16(ADDR_CAP_LO, 16'h5A5A);
		u_cpu.rd16(ADDR_CAP_LO, d16);
		`CHK("cap_wr", 16'h5A5A, d16)
		u_cpu.wr8(ADDR_FLAG, 8'h0F);
		cap_pin <= 1'b0;
		repeat (12) @(posedge i_clk);
		cap_pin <= 1'b1;
		repeat (12) @(posedge i_clk);
		u_cpu.rd8(ADDR_FLAG, d8);
		`CHK("cap_top_no_trig", 8'h00, d8)
		u_cpu.wr16(ADDR_CNT_LO, 16'h5A5A);
		repeat (2) @(posedge i_clk);
		#1;
		`CHK("top_ind", 1'b1, at_top)
		close_out();
	end
endmodule : timer16_counter_capture_tb_top
